// *** hw/gate_drive_defines.svh ***
// Timing constants and counter width for the dual buck gate-drive logic.
// Assumes a single 100 MHz system clock.
`ifndef GATE_DRIVE_DEFINES_SVH
`define GATE_DRIVE_DEFINES_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_PERIOD_NS      10
// ----------------------------------------
// Dead time between switch hand-overs
// ----------------------------------------
`define DEAD_TIME_NS       20
`define DEAD_CYCLES        \
  ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ----------------------------------------
// Three-state hold-off default
// ----------------------------------------
`define HOLDOFF_TIME_NS    100
`define HOLDOFF_CYCLES     \
  ((`HOLDOFF_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              16

`endif

// *** hw/gate_drive_pkg.sv ***
// Types used by the gate-drive channel; its top does not reference them.
// Assumes the defines header is compiled alongside.
`default_nettype none
package gate_drive_pkg;
  // ----------------------------------------
  // Channel drive state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_HIGH_ON  = 3'b001,
    ST_DEAD_LO  = 3'b010,
    ST_LOW_ON   = 3'b011,
    ST_DEAD_HI  = 3'b100,
    ST_TRISTATE = 3'b101
  } drive_state_t;
endpackage
`default_nettype wire

// *** hw/gate_drive_channel.sv ***
// One gate-drive channel: decodes pulse and rectifier enable into switches.
// Assumes inputs are already synchronised to clk_sys_i.
`include "gate_drive_defines.svh"
`default_nettype none
module gate_drive_channel #(
  parameter logic [`CNT_W-1:0] HOLDOFF = `CNT_W'(`HOLDOFF_CYCLES)
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Decoded pulse input
  input  wire logic pulse_high_i,
  input  wire logic pulse_mid_i,
  input  wire logic sync_rectifier_enable_i,
  // Switch commands
  output logic      high_side_switch_o,
  output logic      low_side_switch_o,
  output logic      tristate_o
);
  localparam logic [`CNT_W-1:0] DEAD = `CNT_W'(`DEAD_CYCLES);

  gate_drive_pkg::drive_state_t state;
  gate_drive_pkg::drive_state_t next_state;
  logic [`CNT_W-1:0] mid_cnt;
  logic [`CNT_W-1:0] dead_cnt;
  logic              mid_long;
  logic              dead_done;

  // ----------------------------------------
  // Three-state hold-off
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mid_cnt <= `CNT_W'h0;
    end else if (!pulse_mid_i) begin
      mid_cnt <= `CNT_W'h0;
    end else if (mid_cnt < HOLDOFF) begin
      mid_cnt <= mid_cnt + `CNT_W'h1;
    end
  end
  assign mid_long = pulse_mid_i && (mid_cnt >= HOLDOFF);

  // ----------------------------------------
  // Dead-time counter
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dead_cnt <= `CNT_W'h0;
    end else if (state != next_state) begin
      dead_cnt <= `CNT_W'h0;
    end else if (dead_cnt < DEAD) begin
      dead_cnt <= dead_cnt + `CNT_W'h1;
    end
  end
  assign dead_done = (dead_cnt >= DEAD - `CNT_W'h1);

  // ----------------------------------------
  // Drive state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    if (mid_long) begin
      next_state = gate_drive_pkg::ST_TRISTATE;
    end else begin
      case (state)
        gate_drive_pkg::ST_HIGH_ON: begin
          if (!pulse_high_i) begin
            // Low side waits out dead time; off directly if not sync
            next_state = sync_rectifier_enable_i ?
                         gate_drive_pkg::ST_DEAD_LO :
                         gate_drive_pkg::ST_OFF;
          end
        end
        gate_drive_pkg::ST_DEAD_LO: begin
          if (pulse_high_i) begin
            next_state = gate_drive_pkg::ST_HIGH_ON;
          end else if (!sync_rectifier_enable_i) begin
            next_state = gate_drive_pkg::ST_OFF;
          end else if (dead_done) begin
            next_state = gate_drive_pkg::ST_LOW_ON;
          end
        end
        gate_drive_pkg::ST_LOW_ON: begin
          if (pulse_high_i || !sync_rectifier_enable_i) begin
            next_state = gate_drive_pkg::ST_DEAD_HI;
          end
        end
        gate_drive_pkg::ST_DEAD_HI: begin
          if (!pulse_high_i) begin
            next_state = sync_rectifier_enable_i ?
                         gate_drive_pkg::ST_LOW_ON :
                         gate_drive_pkg::ST_OFF;
          end else if (dead_done) begin
            next_state = gate_drive_pkg::ST_HIGH_ON;
          end
        end
        gate_drive_pkg::ST_TRISTATE: begin
          // Exit only on a low pulse level; high side stays off meanwhile
          if (!pulse_mid_i && !pulse_high_i) begin
            next_state = sync_rectifier_enable_i ?
                         gate_drive_pkg::ST_DEAD_LO :
                         gate_drive_pkg::ST_OFF;
          end
        end
        default: begin
          if (pulse_high_i && !pulse_mid_i) begin
            next_state = gate_drive_pkg::ST_HIGH_ON;
          end else if (!pulse_mid_i && sync_rectifier_enable_i) begin
            next_state = gate_drive_pkg::ST_DEAD_LO;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= gate_drive_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Registered switch commands
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      high_side_switch_o <= 1'b0;
      low_side_switch_o  <= 1'b0;
      tristate_o         <= 1'b0;
    end else begin
      high_side_switch_o <= (next_state == gate_drive_pkg::ST_HIGH_ON);
      low_side_switch_o  <= (next_state == gate_drive_pkg::ST_LOW_ON);
      tristate_o         <= (next_state == gate_drive_pkg::ST_TRISTATE);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_no_overlap: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !(high_side_switch_o && low_side_switch_o))
    else $error("both switches on");

  a_nosync_low_off: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !sync_rectifier_enable_i [*2] |-> !low_side_switch_o)
    else $error("low side on without rectifier enable");

  a_tristate_off: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    tristate_o |-> !high_side_switch_o && !low_side_switch_o)
    else $error("switch on in three-state");

  a_hs_dead_gap: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(low_side_switch_o) |-> !high_side_switch_o [*2])
    else $error("high side on before dead time");

  a_holdoff_len: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(tristate_o) |-> $past(mid_cnt) >= HOLDOFF)
    else $error("three-state entered before hold-off");

  a_ls_dead_gap: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(high_side_switch_o) |-> !low_side_switch_o [*2])
    else $error("low side on before dead time");

  a_tristate_hold: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    tristate_o && (pulse_mid_i || pulse_high_i) |=> tristate_o)
    else $error("three-state left without a low pulse");
endmodule
`default_nettype wire

// *** hw/buck_gate_drive.sv ***
// Top of the dual-channel buck gate-drive logic: input sync plus channels.
// Assumes pulse inputs arrive pre-classified as high and mid-band levels.
`include "gate_drive_defines.svh"
`default_nettype none
module buck_gate_drive #(
  parameter logic [`CNT_W-1:0] HOLDOFF = `CNT_W'(`HOLDOFF_CYCLES)
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Controller inputs, index 0 is channel A
  input  wire logic [1:0] pulse_high_i,
  input  wire logic [1:0] pulse_mid_i,
  input  wire logic [1:0] sync_rectifier_enable_i,
  // Switch commands
  output logic      [1:0] high_side_switch_o,
  output logic      [1:0] low_side_switch_o,
  output logic      [1:0] tristate_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [5:0] sync_a;
  logic [5:0] sync_b;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {sync_rectifier_enable_i, pulse_mid_i, pulse_high_i};
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    gate_drive_channel #(
      .HOLDOFF(HOLDOFF)
    ) u_chan (
      .clk_sys_i              (clk_sys_i),
      .rst_i                  (rst_i),
      .pulse_high_i           (sync_b[ch]),
      .pulse_mid_i            (sync_b[2 + ch]),
      .sync_rectifier_enable_i(sync_b[4 + ch]),
      .high_side_switch_o     (high_side_switch_o[ch]),
      .low_side_switch_o      (low_side_switch_o[ch]),
      .tristate_o             (tristate_o[ch])
    );
  end
endmodule
`default_nettype wire

// *** sim/pwm_ctrl_model.sv ***
// Behavioural pulse-width controller driving both gate-drive channels.
// Assumes the bench sets requested levels just after a clock edge.
`default_nettype none
module pwm_ctrl_model (
  // Requested level per channel: 0 low, 1 high, 2 released
  input  wire logic [3:0] lvl_i,
  input  wire logic [1:0] en_i,
  // Lines to the gate-drive logic
  output logic      [1:0] pulse_high_o,
  output logic      [1:0] pulse_mid_o,
  output logic      [1:0] enable_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Full swing only, so high and mid never show together
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pulse_high_o[c] = (lvl_i[2*c+:2] == 2'h1);
      pulse_mid_o[c]  = (lvl_i[2*c+:2] == 2'h2);
    end
  end
  assign enable_o = en_i;
endmodule
`default_nettype wire

// *** sim/tb_buck_gate_drive.sv ***
// Self-checking bench for the dual gate-drive logic.
// Assumes the controller model and the design files are compiled first.
`include "gate_drive_defines.svh"
`default_nettype none
module tb_buck_gate_drive;
  timeunit 1ns;
  timeprecision 100ps;
  // Small hold-off keeps the run short
  localparam int HOLD = 3;
  logic       clk_sys_i;
  logic       rst_i;
  logic [3:0] lvl;
  logic [1:0] en;
  logic [1:0] p_high;
  logic [1:0] p_mid;
  logic [1:0] p_en;
  logic [1:0] hs;
  logic [1:0] ls;
  logic [1:0] tri_st;
  int         fail_count;
  int         checks;
  pwm_ctrl_model u_pwm_ctrl_model (.lvl_i(lvl), .en_i(en),
    .pulse_high_o(p_high), .pulse_mid_o(p_mid), .enable_o(p_en));
  buck_gate_drive #(.HOLDOFF(`CNT_W'(HOLD))) u_buck_gate_drive (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pulse_high_i(p_high),
    .pulse_mid_i(p_mid), .sync_rectifier_enable_i(p_en),
    .high_side_switch_o(hs), .low_side_switch_o(ls),
    .tristate_o(tri_st));
  task automatic cmp(input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%0h got=%0h", $time, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic drive(input logic [3:0] l, input logic [1:0] e);
    lvl = l;
    en = e;
  endtask
  // Both switches watched each cycle across one hand-over
  task automatic hand_over(input logic [3:0] l);
    logic [1:0] both;
    int         dead;
    both = 2'h0;
    dead = 0;
    drive(l, 2'h3);
    repeat (12) begin
      step(1);
      both = both | (hs & ls);
      if (hs[0] === 1'b0 && ls[0] === 1'b0) dead++;
    end
    cmp(2'h0, both);
    cmp(2'h1, {1'b0, dead >= `DEAD_CYCLES});
  endtask
  task automatic t_sync();
    hand_over(4'h0);
    hand_over(4'h5);
    cmp(2'h3, hs);
    cmp(2'h0, ls);
    hand_over(4'h0);
    cmp(2'h0, hs);
    cmp(2'h3, ls);
  endtask
  task automatic t_nonsync();
    logic [1:0] lo;
    lo = 2'h0;
    drive(4'h5, 2'h0);
    step(8);
    cmp(2'h3, hs);
    cmp(2'h0, ls);
    drive(4'h0, 2'h0);
    repeat (10) begin
      step(1);
      lo = lo | ls;
    end
    cmp(2'h0, hs);
    cmp(2'h0, lo);
  endtask
  // Each channel released in turn while the other keeps switching high
  task automatic t_tristate();
    for (int e = 0; e < 4; e++) begin
      drive(4'h0, 2'h3);
      step(10);
      drive(e[1] ? 4'h9 : 4'h6,
            e[1] ? {e[0], 1'b1} : {1'b1, e[0]});
      step(HOLD + 8);
      cmp(e[1] ? 2'h2 : 2'h1, tri_st);
      cmp(e[1] ? 2'h1 : 2'h2, hs);
      cmp(2'h0, ls);
      drive(4'h0, 2'h3);
      step(10);
      cmp(2'h0, tri_st);
      cmp(2'h3, ls);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard, well past the roughly two hundred cycles of tests
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  initial begin
    fail_count = 0;
    checks = 0;
    rst_i = 1'b1;
    drive(4'h0, 2'h0);
    repeat (16) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    step(2);
    t_sync();
    t_nonsync();
    t_tristate();
    test_done();
  end
endmodule
`default_nettype wire
